// ==== hdl/vlso_line_clk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "vlso_map.svh"
module vlso_line_clk
  import vlso_pkg::*;
#(
  parameter logic [`VLSO_RC_W-1:0] RC_HALF = `VLSO_RC_W'(`VLSO_RC_HALF)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Clock sources and options
  input wire logic xtal_in,
  input wire logic modem_clk,
  input wire logic xtal_present,
  input wire logic xtal_fast,
  input wire logic loop_test,
  // Resulting line clock
  output logic line_clk
);
  vlso_lc_st_t r_reg, r_next;
  logic [`VLSO_XC_W-1:0] xhalf;

  // Crystal divider, RC oscillator and source choice
  always_comb begin
    r_next = r_reg;
    xhalf = xtal_fast ? `VLSO_XC_W'(`VLSO_XDIV_FAST / 2)
                      : `VLSO_XC_W'(`VLSO_XDIV_SLOW / 2);
    r_next.xprev = xtal_in;
    if (xtal_in && !r_reg.xprev) begin
      if (r_reg.xcnt + `VLSO_XC_W'(1) >= xhalf) begin
        r_next.xcnt = '0;
        r_next.xclk = !r_reg.xclk;
      end else begin
        r_next.xcnt = r_reg.xcnt + `VLSO_XC_W'(1);
      end
    end
    if (r_reg.rcnt + `VLSO_RC_W'(1) >= RC_HALF) begin
      r_next.rcnt = '0;
      r_next.rclk = !r_reg.rclk;
    end else begin
      r_next.rcnt = r_reg.rcnt + `VLSO_RC_W'(1);
    end
    if (xtal_present) begin
      r_next.line = r_reg.xclk;
    end else if (loop_test) begin
      r_next.line = r_reg.rclk;
    end else begin
      r_next.line = modem_clk;
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign line_clk = r_reg.line;
endmodule
`default_nettype wire

// ==== hdl/vlso_map.svh ====
`ifndef VLSO_MAP_SVH
`define VLSO_MAP_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define VLSO_OFF_CFG 8'h00
`define VLSO_OFF_STAT 8'h04
`define VLSO_OFF_CLR 8'h08
`define VLSO_OFF_EN 8'h0c
`define VLSO_OFF_VEC 8'h10
`define VLSO_OFF_SYNC 8'h14
// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define VLSO_CFG_W 16
`define VLSO_CFG_VEC_LSB 0
`define VLSO_CFG_VEC_MSB 5
`define VLSO_CFG_B2 6
`define VLSO_CFG_NPR 7
`define VLSO_CFG_TWO_SYNC 8
`define VLSO_CFG_ACT_NS 9
`define VLSO_CFG_EVEN 10
`define VLSO_CFG_XTAL 11
`define VLSO_CFG_FAST 12
`define VLSO_CFG_LOOP 13
`define VLSO_CFG_RXEN 14
`define VLSO_CFG_RST 16'h03d8
// ----------------------------------------
// Event bits, status extras, vector layout
// ----------------------------------------
`define VLSO_EV_W 7
`define VLSO_RX_MASK 7'h07
`define VLSO_TX_MASK 7'h78
`define VLSO_ST_FRAMED 8
`define VLSO_ST_ACTIVE 9
`define VLSO_VEC_W 9
`define VLSO_VEC_RX_LSB 0
`define VLSO_VEC_TX_LSB 16
`define VLSO_VD_W 7
`define VLSO_SYNC_W 8
`define VLSO_SYNC_RST 8'h16
`define VLSO_BR_LEVEL 3'h5
`define VLSO_OKAY 2'b00
`define VLSO_SLVERR 2'b10
// ----------------------------------------
// Timing
// ----------------------------------------
`define VLSO_CLK_HZ 10000000
`define VLSO_RC_BAUD 14000
`define VLSO_RC_HALF (`VLSO_CLK_HZ / (2 * `VLSO_RC_BAUD))
`define VLSO_RC_W 10
`define VLSO_XDIV_SLOW 16
`define VLSO_XDIV_FAST 2
`define VLSO_XC_W 4
`endif

// ==== hdl/vlso_pkg.sv ====
`include "vlso_map.svh"
package vlso_pkg;
  // Vector drive phases
  typedef enum logic [1:0] {VS_IDLE, VS_RX, VS_TX} vlso_vs_t;

  // Top-level state
  typedef struct packed {
    logic [`VLSO_CFG_W-1:0] cfg;
    logic [`VLSO_SYNC_W-1:0] sync;
    logic [`VLSO_EV_W-1:0] stat;
    logic [`VLSO_EV_W-1:0] en;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    vlso_vs_t vs;
    logic [`VLSO_VD_W-1:0] vec;
    logic vec_oe;
  } vlso_top_st_t;

  // Receive framing state
  typedef struct packed {
    logic [1:0] scnt;
    logic framed;
    logic active;
    logic perr;
  } vlso_rx_st_t;

  // Line clock state
  typedef struct packed {
    logic xprev;
    logic [`VLSO_XC_W-1:0] xcnt;
    logic xclk;
    logic [`VLSO_RC_W-1:0] rcnt;
    logic rclk;
    logic line;
  } vlso_lc_st_t;
endpackage

// ==== hdl/vlso_rx_frame.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "vlso_map.svh"
module vlso_rx_frame
  import vlso_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Character stream and results
  vlso_rx_if.frame rx
);
  vlso_rx_st_t r_reg, r_next;
  logic is_sync;
  logic par_x;

  // Sync hunt, receive active and parity check
  always_comb begin
    r_next = r_reg;
    r_next.perr = 1'b0;
    is_sync = (rx.ch == rx.sync_ch);
    par_x = ^{rx.ch, rx.par_bit};
    if (!rx.rx_en) begin
      r_next.scnt = '0;
      r_next.framed = 1'b0;
      r_next.active = 1'b0;
    end else if (rx.ch_valid) begin
      if (!r_reg.framed) begin
        if (is_sync) begin
          r_next.scnt = r_reg.scnt + 2'd1;
          if (rx.two_sync ? (r_reg.scnt != 2'd0) : 1'b1) begin
            r_next.framed = 1'b1;
            r_next.active = !rx.act_nonsync;
          end
        end else begin
          r_next.scnt = '0;
        end
      end else if (!is_sync) begin
        r_next.active = 1'b1;
        r_next.perr = rx.even_par ? par_x : !par_x;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rx.framed = r_reg.framed;
  assign rx.active = r_reg.active;
  assign rx.par_err = r_reg.perr;
endmodule
`default_nettype wire

// ==== hdl/vlso_rx_if.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "vlso_map.svh"
interface vlso_rx_if;
  logic ch_valid;
  logic [`VLSO_SYNC_W-1:0] ch;
  logic par_bit;
  logic [`VLSO_SYNC_W-1:0] sync_ch;
  logic two_sync;
  logic act_nonsync;
  logic even_par;
  logic rx_en;
  logic framed;
  logic active;
  logic par_err;
  modport owner (output ch_valid, ch, par_bit, sync_ch, two_sync, act_nonsync, even_par, rx_en,
                 input framed, active, par_err);
  modport frame (input ch_valid, ch, par_bit, sync_ch, two_sync, act_nonsync, even_par, rx_en,
                 output framed, active, par_err);
endinterface
`default_nettype wire

// ==== hdl/vlso_top.sv ====
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "vlso_map.svh"
module vlso_top
  import vlso_pkg::*;
#(
  parameter int AW = 8,
  parameter logic [2:0] PRIO = `VLSO_BR_LEVEL
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // AXI4-Lite write address and data
  input wire logic [AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Interrupt events from the line logic
  input wire logic RX_DONE_P,
  input wire logic RX_DONE_S,
  input wire logic CHAR_FLAG,
  input wire logic TX_DONE_P,
  input wire logic TX_DONE_S,
  input wire logic ERR_FLAG,
  input wire logic DSET_FLAG,
  // Interrupt request and vector drive
  output logic IRQ,
  output logic RX_REQ,
  output logic TX_REQ,
  output logic [2:0] BR_LEVEL,
  output logic NPR_FAST,
  input wire logic INT_GRANT,
  output logic [`VLSO_VD_W-1:0] VEC_D,
  output logic VEC_OE,
  // Received characters
  input wire logic CH_VALID,
  input wire logic [`VLSO_SYNC_W-1:0] CH_DATA,
  input wire logic CH_PAR,
  output logic FRAMED,
  output logic RX_ACTIVE,
  // Line clocking
  input wire logic XTAL_IN,
  input wire logic MODEM_CLK,
  output logic LINE_CLK
);
  vlso_top_st_t r_reg, r_next;
  vlso_rx_if rxi ();
  logic [31:0] mask;
  logic [31:0] rd;
  logic [`VLSO_EV_W-1:0] ev;
  logic [`VLSO_EV_W-1:0] clr;
  logic [`VLSO_EV_W-1:0] pend;
  logic [`VLSO_VD_W-2:0] vhi;
  logic [`VLSO_VD_W-1:0] vec_rx;
  logic [`VLSO_VD_W-1:0] vec_tx;
  logic wr_ok;
  logic rd_ok;
  logic req_rx;
  logic req_tx;

  // ----------------------------------------
  // Submodules
  // ----------------------------------------

  // Framing and parity
  vlso_rx_frame u_frame (
    .clk(CLK),
    .arst_n(ARST_N),
    .rx(rxi.frame)
  );

  // Line clock source
  vlso_line_clk u_lclk (
    .clk(CLK),
    .arst_n(ARST_N),
    .xtal_in(XTAL_IN),
    .modem_clk(MODEM_CLK),
    .xtal_present(r_reg.cfg[`VLSO_CFG_XTAL]),
    .xtal_fast(r_reg.cfg[`VLSO_CFG_FAST]),
    .loop_test(r_reg.cfg[`VLSO_CFG_LOOP]),
    .line_clk(LINE_CLK)
  );

  // Options handed to the framing logic
  assign rxi.ch_valid = CH_VALID;
  assign rxi.ch = CH_DATA;
  assign rxi.par_bit = CH_PAR;
  assign rxi.sync_ch = r_reg.sync;
  assign rxi.two_sync = r_reg.cfg[`VLSO_CFG_TWO_SYNC];
  assign rxi.act_nonsync = r_reg.cfg[`VLSO_CFG_ACT_NS];
  assign rxi.even_par = r_reg.cfg[`VLSO_CFG_EVEN];
  assign rxi.rx_en = r_reg.cfg[`VLSO_CFG_RXEN];

  // ----------------------------------------
  // Request decode
  // ----------------------------------------

  // Enabled events split into the two vector groups
  assign pend = r_reg.stat & r_reg.en;
  assign req_rx = |(pend & `VLSO_RX_MASK);
  assign req_tx = |(pend & `VLSO_TX_MASK);
  assign vhi = r_reg.cfg[`VLSO_CFG_VEC_MSB:`VLSO_CFG_VEC_LSB];

  // ----------------------------------------
  // Vector words, events and bus acceptance
  // ----------------------------------------

  // Vector bits 8..2 of each side; bits 1 and 0 are never sent
  assign vec_rx = {vhi, 1'b0};
  assign vec_tx = {vhi, r_reg.cfg[`VLSO_CFG_B2]};

  // Events in status bit order; parity errors join the error flag
  assign ev = {DSET_FLAG, ERR_FLAG | rxi.par_err, TX_DONE_S, TX_DONE_P, CHAR_FLAG, RX_DONE_S, RX_DONE_P};

  // A write needs both halves and no answer pending, so both are taken together
  assign wr_ok = S_AXI_AWVALID && S_AXI_WVALID && !r_reg.bvalid;
  assign rd_ok = S_AXI_ARVALID && !r_reg.rvalid;

  // Byte lane mask, one lane per write strobe
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign mask[8*g +: 8] = {8{S_AXI_WSTRB[g]}};
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------

  // Bus slave, sticky status and vector sequencing
  always_comb begin
    r_next = r_reg;
    clr = '0;
    rd = '0;
    // Write channel
    if (r_reg.bvalid && S_AXI_BREADY) begin
      r_next.bvalid = 1'b0;
    end
    if (wr_ok) begin
      r_next.bvalid = 1'b1;
      r_next.bresp = `VLSO_OKAY;
      case (S_AXI_AWADDR[7:0])
        `VLSO_OFF_CFG: begin
          r_next.cfg = (r_reg.cfg & ~mask[`VLSO_CFG_W-1:0]) | (S_AXI_WDATA[`VLSO_CFG_W-1:0] & mask[`VLSO_CFG_W-1:0]);
        end
        `VLSO_OFF_CLR: begin
          clr = S_AXI_WDATA[`VLSO_EV_W-1:0] & mask[`VLSO_EV_W-1:0];
        end
        `VLSO_OFF_EN: begin
          r_next.en = (r_reg.en & ~mask[`VLSO_EV_W-1:0]) | (S_AXI_WDATA[`VLSO_EV_W-1:0] & mask[`VLSO_EV_W-1:0]);
        end
        `VLSO_OFF_SYNC: begin
          r_next.sync = (r_reg.sync & ~mask[`VLSO_SYNC_W-1:0]) | (S_AXI_WDATA[`VLSO_SYNC_W-1:0] & mask[`VLSO_SYNC_W-1:0]);
        end
        `VLSO_OFF_STAT, `VLSO_OFF_VEC: begin
          r_next.bresp = `VLSO_OKAY;
        end
        default: begin
          r_next.bresp = `VLSO_SLVERR;
        end
      endcase
    end
    // Set wins over clear
    r_next.stat = (r_reg.stat & ~clr) | ev;
    // Read channel
    if (r_reg.rvalid && S_AXI_RREADY) begin
      r_next.rvalid = 1'b0;
    end
    if (rd_ok) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = `VLSO_OKAY;
      case (S_AXI_ARADDR[7:0])
        `VLSO_OFF_CFG: begin
          rd[`VLSO_CFG_W-1:0] = r_reg.cfg;
        end
        `VLSO_OFF_STAT: begin
          rd[`VLSO_EV_W-1:0] = r_reg.stat;
          rd[`VLSO_ST_FRAMED] = rxi.framed;
          rd[`VLSO_ST_ACTIVE] = rxi.active;
        end
        `VLSO_OFF_CLR: begin
          rd = '0;
        end
        `VLSO_OFF_EN: begin
          rd[`VLSO_EV_W-1:0] = r_reg.en;
        end
        `VLSO_OFF_VEC: begin
          rd[`VLSO_VEC_RX_LSB +: `VLSO_VEC_W] = {vec_rx, 2'b00};
          rd[`VLSO_VEC_TX_LSB +: `VLSO_VEC_W] = {vec_tx, 2'b00};
        end
        `VLSO_OFF_SYNC: begin
          rd[`VLSO_SYNC_W-1:0] = r_reg.sync;
        end
        default: begin
          r_next.rresp = `VLSO_SLVERR;
        end
      endcase
      r_next.rdata = rd;
    end
    // Vector drive during the grant, receiver side first
    case (r_reg.vs)
      VS_IDLE: begin
        if (INT_GRANT && req_rx) begin
          r_next.vs = VS_RX;
          r_next.vec = vec_rx;
          r_next.vec_oe = 1'b1;
        end else if (INT_GRANT && req_tx) begin
          r_next.vs = VS_TX;
          r_next.vec = vec_tx;
          r_next.vec_oe = 1'b1;
        end
      end
      VS_RX, VS_TX: begin
        if (!INT_GRANT) begin
          r_next.vs = VS_IDLE;
          r_next.vec = '0;
          r_next.vec_oe = 1'b0;
        end
      end
      default: begin
        r_next.vs = VS_IDLE;
        r_next.vec = '0;
        r_next.vec_oe = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  // Reset loads the shipped strap setting
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      r_reg <= '0;
      r_reg.cfg <= `VLSO_CFG_RST;
      r_reg.sync <= `VLSO_SYNC_RST;
      r_reg.vs <= VS_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // Bus handshakes
  assign S_AXI_AWREADY = wr_ok;
  assign S_AXI_WREADY = wr_ok;
  assign S_AXI_BVALID = r_reg.bvalid;
  assign S_AXI_BRESP = r_reg.bresp;
  assign S_AXI_ARREADY = rd_ok;
  assign S_AXI_RVALID = r_reg.rvalid;
  assign S_AXI_RDATA = r_reg.rdata;
  assign S_AXI_RRESP = r_reg.rresp;

  // Interrupt request and vector pins
  assign IRQ = req_rx | req_tx;
  assign RX_REQ = req_rx;
  assign TX_REQ = req_tx;
  assign BR_LEVEL = PRIO;
  assign NPR_FAST = r_reg.cfg[`VLSO_CFG_NPR];
  assign VEC_D = r_reg.vec;
  assign VEC_OE = r_reg.vec_oe;

  // Framing state
  assign FRAMED = rxi.framed;
  assign RX_ACTIVE = rxi.active;
endmodule
`default_nettype wire

// ==== tb/test_vector_and_line_strap_options.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "vlso_map.svh"
module test_vector_and_line_strap_options;
  logic clk = 0, arst_n = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, chv = 0, chp = 0, xtal = 0, mclk = 0;
  logic [7:0] awa = 0, ara = 0, chd = 0, lf = 8'd41, hcnt;
  logic [31:0] wd = 0, rdt, rdat;
  logic [6:0] ev = 0, vd;
  logic [3:0] dly = 0;
  logic [2:0] brl;
  logic [1:0] br, rr, rsp;
  logic [8:0] hvec;
  logic awr, wr_r, bv, arr, rv, irq, rxq, txq, npr, grant, voe, frm, act, lck;
  int err_count = 0, n_compared = 0;
  localparam logic [2:0] LM [5] = '{3'b100, 3'b110, 3'b101, 3'b001, 3'b000};
  // Clock
  always #50 clk = ~clk;
  vlso_top DUT (.CLK(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdt), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy), .RX_DONE_P(ev[0]),
    .RX_DONE_S(ev[1]), .CHAR_FLAG(ev[2]), .TX_DONE_P(ev[3]), .TX_DONE_S(ev[4]), .ERR_FLAG(ev[5]),
    .DSET_FLAG(ev[6]), .IRQ(irq), .RX_REQ(rxq), .TX_REQ(txq), .BR_LEVEL(brl), .NPR_FAST(npr),
    .INT_GRANT(grant), .VEC_D(vd), .VEC_OE(voe), .CH_VALID(chv), .CH_DATA(chd), .CH_PAR(chp),
    .FRAMED(frm), .RX_ACTIVE(act), .XTAL_IN(xtal), .MODEM_CLK(mclk), .LINE_CLK(lck));
  vlso_host u_host (.clk(clk), .arst_n(arst_n), .irq(irq), .vec_oe(voe), .vec_d(vd), .dly(dly),
    .grant(grant), .vec(hvec), .cnt(hcnt));
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [8:0] vexp(input logic [5:0] v, input logic tx);
    return {v, tx, 2'b00};
  endfunction
  function automatic int lcexp(input logic [2:0] m, input int n);
    if (m[2]) return n / 4 / (m[1] ? 1 : 8);
    return m[0] ? n / (2 * `VLSO_RC_HALF) * 2 : n / 3;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (!awr && n < 99);
    awv <= 1'b0;
    wv <= 1'b0;
    while (!bv && n < 99) begin @(posedge clk); n++; end
    rsp = br;
    brdy <= 1'b0;
    chk(32'(n < 99), 32'h1);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    int n;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (!arr && n < 99);
    arv <= 1'b0;
    while (!rv && n < 99) begin @(posedge clk); n++; end
    rdat = rdt;
    rsp = rr;
    rrdy <= 1'b0;
    chk(rdat, e);
    chk(32'(n < 99), 32'h1);
  endtask
  task automatic sendc(input logic [7:0] d, input logic p);
    @(posedge clk);
    chd <= d;
    chp <= p;
    chv <= 1'b1;
    @(posedge clk);
    chv <= 1'b0;
  endtask
  task automatic results();
    $display("mismatches %0d comparisons %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    wt(40000);
    err_count++;
    results();
  end
  // Main sequence
  initial begin
    logic [5:0] v;
    logic [7:0] s, c;
    logic [31:0] c0;
    logic l, p;
    int tg, n;
    wt(10);
    arst_n <= 1'b1;
    rchk(`VLSO_OFF_CFG, 32'h3d8);
    rchk(`VLSO_OFF_SYNC, 32'h16);
    rchk(`VLSO_OFF_STAT, 32'h0);
    wr(`VLSO_OFF_VEC, 32'hffff_ffff);
    chk(32'(rsp), 32'(`VLSO_OKAY));
    rchk(`VLSO_OFF_VEC, 32'h00c4_00c0);
    chk(32'(rsp), 32'(`VLSO_OKAY));
    rchk(8'h18, 32'h0);
    chk(32'(rsp), 32'(`VLSO_SLVERR));
    wr(8'h18, 32'hffff_ffff);
    chk(32'(rsp), 32'(`VLSO_SLVERR));
    chk(32'(brl), 32'h5);
    chk(32'(npr), 32'h1);
    wr(`VLSO_OFF_EN, 32'h7f);
    for (int k = 0; k < 4; k++) begin
      v = k[0] ? 6'h3f : 6'h18;
      if (k > 1) begin
        do begin
          lf = nx(lf);
          v = lf[5:0];
        end while (v < 6'h18 || (v >= 6'h28 && v <= 6'h2b));
      end
      wr(`VLSO_OFF_CFG, {24'h0, 2'b11, v});
      rchk(`VLSO_OFF_VEC, {7'h0, vexp(v, 1'b1), 7'h0, vexp(v, 1'b0)});
      for (int i = 0; i < 7; i++) begin
        lf = nx(lf);
        dly <= lf[3:0];
        c = hcnt;
        ev[i] <= 1'b1;
        wt(1);
        ev[i] <= 1'b0;
        n = 0;
        while (hcnt === c && n < 99) begin wt(1); n++; end
        chk(32'(n < 99), 32'h1);
        chk(32'(hvec), 32'(vexp(v, i > 2)));
        rchk(`VLSO_OFF_STAT, 32'h1 << i);
        wr(`VLSO_OFF_CLR, 32'h1 << i);
        wt(8);
        rchk(`VLSO_OFF_STAT, 32'h0);
      end
    end
    wr(`VLSO_OFF_EN, 32'h0);
    ev[3] <= 1'b1;
    wt(1);
    ev[3] <= 1'b0;
    wt(3);
    chk(32'(irq), 32'h0);
    wr(`VLSO_OFF_EN, 32'h8);
    chk(32'(txq), 32'h1);
    chk(32'(rxq), 32'h0);
    wr(`VLSO_OFF_CLR, 32'h8);
    wr(`VLSO_OFF_EN, 32'h0);
    // Event in the cycle of its own clear: the set wins
    fork
      wr(`VLSO_OFF_CLR, 32'h1);
      begin
        @(posedge clk);
        ev[0] <= 1'b1;
        @(posedge clk);
        ev[0] <= 1'b0;
      end
    join
    rchk(`VLSO_OFF_STAT, 32'h1);
    wr(`VLSO_OFF_CLR, 32'h1);
    rchk(`VLSO_OFF_STAT, 32'h0);
    for (int k = 0; k < 8; k++) begin
      lf = nx(lf);
      s = lf;
      wr(`VLSO_OFF_SYNC, 32'(s));
      c0 = {21'h0, 3'(k), 8'hd8};
      wr(`VLSO_OFF_CFG, c0);
      wr(`VLSO_OFF_CFG, c0 | 32'h4000);
      p = (^(~s)) ^ !k[2];
      if (k[0]) begin
        sendc(s, 1'b0);
        sendc(~s, 1'b0);
        sendc(s, 1'b0);
        wt(1);
        chk(32'(frm), 32'h0);
      end
      sendc(s, 1'b0);
      wt(1);
      chk(32'(frm), 32'h1);
      chk(32'(act), 32'(!k[1]));
      sendc(~s, !p);
      wt(3);
      chk(32'(act), 32'h1);
      rchk(`VLSO_OFF_STAT, 32'h320);
      wr(`VLSO_OFF_CLR, 32'h20);
      sendc(~s, p);
      wt(3);
      rchk(`VLSO_OFF_STAT, 32'h300);
    end
    for (int m = 0; m < 5; m++) begin
      wr(`VLSO_OFF_CFG, {18'h0, LM[m][0], LM[m][1], LM[m][2], 11'h0d8});
      tg = 0;
      l = lck;
      for (int i = 0; i < 3600; i++) begin
        @(posedge clk);
        if (i % 2 == 0) xtal <= ~xtal;
        if (i % 3 == 0) mclk <= ~mclk;
        if (lck !== l) tg++;
        l = lck;
      end
      chk(32'(tg >= lcexp(LM[m], 3600) - 2 && tg <= lcexp(LM[m], 3600) + 2), 32'h1);
    end
    results();
  end
endmodule
`default_nettype wire

// ==== tb/vlso_chk_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "vlso_map.svh"
module vlso_chk #(
  parameter logic [2:0] PRIO = 3'h5
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Bus handshakes
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_RVALID,
  // Interrupt side
  input wire logic IRQ,
  input wire logic RX_REQ,
  input wire logic TX_REQ,
  input wire logic [2:0] BR_LEVEL,
  input wire logic INT_GRANT,
  input wire logic [`VLSO_VD_W-1:0] VEC_D,
  input wire logic VEC_OE,
  // Receive state
  input wire logic FRAMED,
  input wire logic RX_ACTIVE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_WR_ANS: assert property (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID |=> S_AXI_BVALID)
    else $error("write not answered");
  AST_WR_END: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answer did not end");
  AST_RD_ANS: assert property (S_AXI_ARVALID && !S_AXI_RVALID |=> S_AXI_RVALID)
    else $error("read not answered");
  AST_REQ_OR: assert property (IRQ == (RX_REQ || TX_REQ))
    else $error("request not the sum of both sides");
  AST_PRIO: assert property (BR_LEVEL == PRIO)
    else $error("wrong priority level");
  AST_VEC_ZERO: assert property (!VEC_OE |-> VEC_D == '0)
    else $error("vector lines driven while idle");
  AST_VEC_GRANT: assert property ($rose(VEC_OE) |-> $past(INT_GRANT) && $past(IRQ))
    else $error("vector without grant");
  AST_VEC_RX: assert property ($rose(VEC_OE) && $past(RX_REQ) |-> !VEC_D[0])
    else $error("receiver vector does not end in 0");
  AST_VEC_HOLD: assert property (VEC_OE && $past(VEC_OE) |-> $stable(VEC_D))
    else $error("vector changed during grant");
  AST_VEC_DROP: assert property (!INT_GRANT [*3] |=> !VEC_OE)
    else $error("vector kept after grant ended");
  AST_VEC_ANS: assert property ($rose(INT_GRANT) && IRQ && !VEC_OE |=> VEC_OE)
    else $error("grant not answered");
  AST_ACT_FRM: assert property (RX_ACTIVE |-> FRAMED)
    else $error("active without framing");
endmodule
bind vlso_top vlso_chk #(.PRIO(PRIO)) u_chk (.CLK(CLK), .ARST_N(ARST_N), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_RVALID(S_AXI_RVALID), .IRQ(IRQ), .RX_REQ(RX_REQ), .TX_REQ(TX_REQ),
  .BR_LEVEL(BR_LEVEL), .INT_GRANT(INT_GRANT), .VEC_D(VEC_D), .VEC_OE(VEC_OE), .FRAMED(FRAMED),
  .RX_ACTIVE(RX_ACTIVE));
`default_nettype wire

// ==== tb/vlso_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module vlso_host (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Device side
  input wire logic irq,
  input wire logic vec_oe,
  input wire logic [6:0] vec_d,
  input wire logic [3:0] dly,
  output logic grant,
  // Captured vector and count
  output logic [8:0] vec,
  output logic [7:0] cnt
);
  logic [1:0] st;
  logic [3:0] n;
  // Grant after a variable wait, take the vector, wait for release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= 2'd0;
      n <= 4'h0;
      grant <= 1'b0;
      vec <= 9'h000;
      cnt <= 8'h00;
    end else begin
      case (st)
        2'd0: if (irq) begin
          n <= n + 4'h1;
          if (n >= dly) begin
            grant <= 1'b1;
            st <= 2'd1;
            n <= 4'h0;
          end
        end
        2'd1: if (vec_oe) begin
          vec <= {vec_d, 2'b00};
          cnt <= cnt + 8'h01;
          grant <= 1'b0;
          st <= 2'd2;
        end
        default: if (!vec_oe) st <= 2'd0;
      endcase
    end
  end
endmodule
`default_nettype wire
